/* smc_defs.svh */
// constants for the serial client interface: addresses, strap codes, timing
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

`define SMC_ARA_ADDR 7'h0C
`define SMC_ADDR_HI_LOW 4'h9
`define SMC_ADDR_HI_HIGH 4'h5
`define SMC_ADDR_OPEN 7'h18
`define SMC_STRAP_OPEN 4'hF
`define SMC_RW_BIT 0
`define SMC_LAST_BIT 4'h7
`define SMC_ACK_SLOT 4'h8

`define SMC_CLK_HZ 10000000
`define SMC_LOW_TIMEOUT_MS 30
`define SMC_IDLE_TIMEOUT_US 200
`define SMC_LOW_TIMEOUT_CYC \
  ((`SMC_LOW_TIMEOUT_MS * `SMC_CLK_HZ + 999) / 1000)
`define SMC_IDLE_TIMEOUT_CYC \
  ((`SMC_IDLE_TIMEOUT_US * `SMC_CLK_HZ + 999999) / 1000000)

`endif

/* smc_pkg.sv */
// types shared by the serial client interface
package smc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INDEX,
    ST_WDATA,
    ST_RDATA,
    ST_SKIP
  } smc_state_t;

  typedef logic [7:0] smc_byte_t;

endpackage

/* smc_link_front.sv */
// link-clock bit capture and synchronisers into the system clock
`timescale 1ns/1ns
`default_nettype none

module smc_link_front (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic serial_clock_line_i,
  input wire logic sda_i,
  output logic scl_lvl_o,
  output logic sda_lvl_o,
  output logic bit_val_o,
  output logic bit_evt_o
);

  logic link_bit_r;
  logic link_tgl_r;
  logic [2:0] sync_r [3];
  logic [2:0] async_in;
  logic scl_lvl_r;
  logic sda_lvl_r;
  logic tgl_lvl_r;
  logic tgl_seen_r;
  logic bit_val_r;
  logic bit_evt_r;

  // data is sampled on the rising serial clock edge, in its own domain
  always_ff @(posedge serial_clock_line_i or posedge reset_i) begin
    if (reset_i) begin
      link_bit_r <= 1'b1;
      link_tgl_r <= 1'b0;
    end else begin
      link_bit_r <= sda_i;
      link_tgl_r <= ~link_tgl_r;
    end
  end

  assign async_in = {link_tgl_r, sda_i, serial_clock_line_i};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
          sync_r[g] <= (g == 0 || g == 1) ? 3'h7 : 3'h0;
        end else begin
          sync_r[g] <= {sync_r[g][1:0], async_in[g]};
        end
      end
    end
  endgenerate

  // a level counts once the second and third stages agree
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      scl_lvl_r <= 1'b1;
      sda_lvl_r <= 1'b1;
      tgl_lvl_r <= 1'b0;
    end else begin
      if (sync_r[0][1] == sync_r[0][2]) begin
        scl_lvl_r <= sync_r[0][2];
      end
      if (sync_r[1][1] == sync_r[1][2]) begin
        sda_lvl_r <= sync_r[1][2];
      end
      if (sync_r[2][1] == sync_r[2][2]) begin
        tgl_lvl_r <= sync_r[2][2];
      end
    end
  end

  // the captured bit is stable for a whole clock period after its toggle
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tgl_seen_r <= 1'b0;
      bit_val_r <= 1'b1;
      bit_evt_r <= 1'b0;
    end else begin
      tgl_seen_r <= tgl_lvl_r;
      bit_evt_r <= tgl_lvl_r != tgl_seen_r;
      if (tgl_lvl_r != tgl_seen_r) begin
        bit_val_r <= link_bit_r;
      end
    end
  end

  assign scl_lvl_o = scl_lvl_r;
  assign sda_lvl_o = sda_lvl_r;
  assign bit_val_o = bit_val_r;
  assign bit_evt_o = bit_evt_r;

endmodule

`default_nettype wire

/* smc_client.sv */
// two-wire serial client: framing, addressing, acknowledge, timeouts
//
// Notes on behaviour
// [RULE_01] never hold the serial clock low; accept any host clock stretch
// [RULE_02] start is data falling while clock is high
// [RULE_03] stop is data rising while clock is high; protocol returns idle
// [RULE_04] first byte after start is 7-bit address plus direction bit
// [RULE_05] own address decoded from the 16-setting strap, open gives own code
// [RULE_06] every byte is eight bits, most significant bit first
// [RULE_07] pull data low in the ninth clock for data, own address, alert reply
// [RULE_08] host leaves data high on last read byte, then stops
// [RULE_09] with timeout enabled, clock low over 30 ms resets the interface
// [RULE_10] with timeout enabled, both lines high over 200 us resets protocol
// [RULE_11] host clock runs between 10 kHz and 400 kHz
// [RULE_12] multi-byte transfers are unlimited, with no byte-count byte
// [RULE_13] write byte: index then data, both acknowledged, data stored
// [RULE_14] read byte: index, repeated start, read address, one byte returned
// [RULE_15] index followed by stop only loads the register pointer
// [RULE_16] read with no index returns the byte at the current pointer
// [RULE_17] host avoids send and receive byte while device is in standby
// [RULE_18] alert response read returns own address from an alerting client
// [RULE_19] alert response address is acknowledged only while alert is active
// [RULE_20] mask alert only after own address went out without losing contest
// [RULE_21] block write stores consecutive bytes until the stop
// [RULE_22] block read returns consecutive registers until host nacks
// [RULE_23] pointer advances by one after each data byte written or read
// [RULE_24] unmatched address: no acknowledge and rest of transfer ignored
`timescale 1ns/1ns
`default_nettype none
`include "smc_defs.svh"

module smc_client #(
  parameter int LOW_TIMEOUT_CYC = `SMC_LOW_TIMEOUT_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic serial_clock_line_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [3:0] addr_sel_i,
  input wire logic alert_i,
  input wire logic timeout_en_i,
  input wire smc_pkg::smc_byte_t reg_rdata_i,
  output smc_pkg::smc_byte_t reg_addr_o,
  output smc_pkg::smc_byte_t reg_waddr_o,
  output smc_pkg::smc_byte_t reg_wdata_o,
  output logic reg_we_o,
  output logic reg_re_o,
  output logic alert_mask_set_o,
  output logic busy_o
);
  import smc_pkg::*;

  localparam int IDLE_CYC = `SMC_IDLE_TIMEOUT_CYC;

  function automatic logic [6:0] strap_addr(input logic [3:0] code);
    logic [6:0] a;
    a = `SMC_ADDR_OPEN;
    if (code == `SMC_STRAP_OPEN) begin
      a = `SMC_ADDR_OPEN;
    end else if (!code[3]) begin
      a = {`SMC_ADDR_HI_LOW, ~code[2], code[1:0]};
    end else begin
      a = {`SMC_ADDR_HI_HIGH, code[2:0]};
    end
    return a;
  endfunction

  logic scl_lvl;
  logic sda_lvl;
  logic bit_val;
  logic bit_evt;

  smc_link_front u_front (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .serial_clock_line_i(serial_clock_line_i),
    .sda_i(sda_i),
    .scl_lvl_o(scl_lvl),
    .sda_lvl_o(sda_lvl),
    .bit_val_o(bit_val),
    .bit_evt_o(bit_evt)
  );

  smc_state_t state_r;
  logic [6:0] own_addr_r;
  logic scl_prev_r;
  logic sda_prev_r;
  logic [3:0] cnt_r;
  smc_byte_t shift_r;
  smc_byte_t tx_r;
  smc_byte_t ptr_r;
  logic ack_r;
  logic ara_r;
  logic lost_r;
  logic sda_oe_r;
  logic sda_out_r;
  smc_byte_t waddr_r;
  smc_byte_t wdata_r;
  logic we_r;
  logic re_r;
  logic mask_r;
  logic [19:0] low_cnt_r;
  logic [11:0] idle_cnt_r;
  logic timeout_r;
  logic busy_r;

  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic byte_done;
  logic ack_done;
  smc_byte_t rx_byte;

  assign start_det = scl_lvl && scl_prev_r && sda_prev_r && !sda_lvl; // see [RULE_02]
  assign stop_det = scl_lvl && scl_prev_r && !sda_prev_r && sda_lvl; // see [RULE_03]
  assign scl_fall = scl_prev_r && !scl_lvl;
  assign byte_done = bit_evt && (cnt_r == `SMC_LAST_BIT);
  assign ack_done = bit_evt && (cnt_r == `SMC_ACK_SLOT);
  assign rx_byte = {shift_r[6:0], bit_val}; // see [RULE_06]

  // strap is caught while reset is held
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      own_addr_r <= strap_addr(addr_sel_i); // see [RULE_05]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_lvl;
      sda_prev_r <= sda_lvl;
    end
  end

  // clock-low and idle-high timeouts, both gated by the enable input
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      low_cnt_r <= 20'h00000;
      idle_cnt_r <= 12'h000;
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= 1'b0;
      if (!timeout_en_i || scl_lvl) begin
        low_cnt_r <= 20'h00000;
      end else if (low_cnt_r == 20'(LOW_TIMEOUT_CYC)) begin
        low_cnt_r <= 20'h00000;
        timeout_r <= 1'b1; // see [RULE_09]
      end else begin
        low_cnt_r <= low_cnt_r + 20'h00001;
      end
      if (!timeout_en_i || !scl_lvl || !sda_lvl || state_r == ST_IDLE) begin
        idle_cnt_r <= 12'h000;
      end else if (idle_cnt_r == 12'(IDLE_CYC)) begin
        idle_cnt_r <= 12'h000;
        timeout_r <= 1'b1; // see [RULE_10]
      end else begin
        idle_cnt_r <= idle_cnt_r + 12'h001;
      end
    end
  end

  // protocol state, bit counter and shift register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ack_r <= 1'b0;
      ara_r <= 1'b0;
      lost_r <= 1'b0;
    end else if (stop_det || timeout_r) begin
      state_r <= ST_IDLE; // see [RULE_03]
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
      ara_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_ADDR; // see [RULE_02]
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
      ara_r <= 1'b0;
      lost_r <= 1'b0;
    end else if (bit_evt && state_r != ST_IDLE && state_r != ST_SKIP) begin
      if (ack_done) begin
        cnt_r <= 4'h0;
        ack_r <= 1'b0;
        if (state_r == ST_RDATA && !ack_r && (bit_val || ara_r)) begin
          state_r <= ST_SKIP; // see [RULE_08]
        end
      end else begin
        cnt_r <= cnt_r + 4'h1;
        shift_r <= rx_byte;
        if (state_r == ST_RDATA && tx_r[3'(7 - cnt_r)] && !bit_val) begin
          lost_r <= 1'b1;
          state_r <= ST_SKIP;
        end else if (byte_done) begin
          unique case (state_r)
            ST_ADDR: begin
              if (rx_byte[7:1] == own_addr_r) begin
                ack_r <= 1'b1; // see [RULE_07]
                state_r <= rx_byte[`SMC_RW_BIT] ? ST_RDATA : ST_INDEX; // see [RULE_04]
              end else if (rx_byte[7:1] == `SMC_ARA_ADDR &&
                           rx_byte[`SMC_RW_BIT] && alert_i) begin
                ack_r <= 1'b1; // see [RULE_19]
                ara_r <= 1'b1;
                state_r <= ST_RDATA;
              end else begin
                state_r <= ST_SKIP; // see [RULE_24]
              end
            end
            ST_INDEX: begin
              ack_r <= 1'b1;
              state_r <= ST_WDATA;
            end
            ST_WDATA: begin
              ack_r <= 1'b1; // see [RULE_12]
            end
            ST_RDATA: begin
              ack_r <= 1'b0;
            end
            ST_IDLE, ST_SKIP: begin
              ack_r <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // register pointer, write address and data, and write strobe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ptr_r <= 8'h00;
      waddr_r <= 8'h00;
      wdata_r <= 8'h00;
      we_r <= 1'b0;
    end else begin
      we_r <= 1'b0;
      if (byte_done && !start_det && !stop_det && !timeout_r) begin
        if (state_r == ST_INDEX) begin
          ptr_r <= rx_byte; // see [RULE_15]
        end else if (state_r == ST_WDATA) begin
          waddr_r <= ptr_r; // see [RULE_13]
          wdata_r <= rx_byte;
          we_r <= 1'b1;
          ptr_r <= ptr_r + 8'h01; // see [RULE_21]
        end else if (state_r == ST_RDATA && !ara_r && !lost_r) begin
          ptr_r <= ptr_r + 8'h01; // see [RULE_23]
        end
      end
    end
  end

  // transmit byte: loaded at the clock fall that starts its first bit
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tx_r <= 8'h00;
      re_r <= 1'b0;
    end else begin
      re_r <= 1'b0;
      if (scl_fall && state_r == ST_RDATA && cnt_r == 4'h0) begin
        if (ara_r) begin
          tx_r <= {own_addr_r, 1'b1}; // see [RULE_18]
        end else begin
          tx_r <= reg_rdata_i; // see [RULE_14] see [RULE_16] see [RULE_22]
          re_r <= 1'b1;
        end
      end
    end
  end

  // data pin changes only while the clock is low; the clock is never driven
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
    end else begin
      sda_out_r <= 1'b0; // see [RULE_01]
      if (stop_det || start_det || timeout_r || state_r == ST_SKIP) begin
        sda_oe_r <= 1'b0;
      end else if (scl_fall) begin
        if (cnt_r == `SMC_ACK_SLOT) begin
          sda_oe_r <= ack_r; // see [RULE_07]
        end else if (state_r == ST_RDATA && cnt_r == 4'h0) begin
          sda_oe_r <= ara_r ? !own_addr_r[6] : !reg_rdata_i[7];
        end else if (state_r == ST_RDATA) begin
          sda_oe_r <= !tx_r[3'(7 - cnt_r)]; // see [RULE_06]
        end else begin
          sda_oe_r <= 1'b0;
        end
      end
    end
  end

  // alert mask request once the whole own address went out intact
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mask_r <= 1'b0;
    end else begin
      mask_r <= byte_done && state_r == ST_RDATA && ara_r && !lost_r &&
                !(tx_r[0] && !bit_val) && !start_det && !stop_det; // see [RULE_20]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= state_r != ST_IDLE;
    end
  end

  assign sda_o = sda_out_r;
  assign sda_oe_o = sda_oe_r;
  assign reg_addr_o = ptr_r;
  assign reg_waddr_o = waddr_r;
  assign reg_wdata_o = wdata_r;
  assign reg_we_o = we_r;
  assign reg_re_o = re_r;
  assign alert_mask_set_o = mask_r;
  assign busy_o = busy_r;

endmodule

`default_nettype wire

/* smc_host_model.sv */
// host controller model for the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module smc_host_model #(
  parameter int Q = 1212
) (
  output var logic scl_o,
  output wire logic sda_o,
  input wire logic dev_oe_i
);
  logic sda_drv;
  int stretch;
  // released data line floats high through the pull-up
  assign sda_o = sda_drv & ~dev_oe_i;
  initial begin
    scl_o = 1'b1;
    sda_drv = 1'b1;
    stretch = 0;
  end
  task start_cond();
    sda_drv = 1'b1;
    #(Q);
    scl_o = 1'b1;
    #(Q);
    sda_drv = 1'b0;
    #(Q);
    scl_o = 1'b0;
  endtask
  task stop_cond();
    #(Q);
    sda_drv = 1'b0;
    #(Q);
    scl_o = 1'b1;
    #(Q);
    sda_drv = 1'b1;
    #(2 * Q);
  endtask
  // quarter period Q keeps the clock near 206 kHz
  task xbyte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #(Q + stretch);
      sda_drv = tx[i];
      #(Q);
      scl_o = 1'b1;
      #(Q);
      rx[i] = sda_o;
      #(Q);
      scl_o = 1'b0;
    end
  endtask
  task park_high(input int ns);
    #(Q);
    scl_o = 1'b1;
    #(ns);
    scl_o = 1'b0;
  endtask
endmodule
`default_nettype wire

/* smc_client_sva.sv */
// concurrent checks on the serial client ports
`timescale 1ns/1ns
`default_nettype none
module smc_client_sva #(
  parameter int LOW_TIMEOUT_CYC = 200
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic serial_clock_line_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic alert_i,
  input wire logic timeout_en_i,
  input wire smc_pkg::smc_byte_t reg_addr_o,
  input wire smc_pkg::smc_byte_t reg_waddr_o,
  input wire logic reg_we_o,
  input wire logic reg_re_o,
  input wire logic alert_mask_set_o,
  input wire logic busy_o
);
  import smc_pkg::*;
  logic [15:0] low_r;
  logic [15:0] hi_r;
  // cycles of clock low, and of both lines high, with timeouts enabled
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !timeout_en_i || serial_clock_line_i)
      low_r <= '0;
    else if (low_r != 16'hFFFF)
      low_r <= low_r + 16'h0001;
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !timeout_en_i || !(serial_clock_line_i && sda_i))
      hi_r <= '0;
    else if (hi_r != 16'hFFFF)
      hi_r <= hi_r + 16'h0001;
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  property p_od;
    sda_o == 1'b0;
  endproperty
  a_od: assert property (p_od)
    else $error("data driven high");
  property p_oe;
    $rose(sda_oe_o) |-> !serial_clock_line_i;
  endproperty
  a_oe: assert property (p_oe)
    else $error("data moved in clock high");
  property p_start;
    $fell(sda_i) && serial_clock_line_i && $past(serial_clock_line_i)
      |-> ##[1:10] busy_o;
  endproperty
  a_start: assert property (p_start)
    else $error("start missed");
  property p_stop;
    $rose(sda_i) && serial_clock_line_i && $past(serial_clock_line_i)
      |-> ##[1:10] !busy_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop missed");
  property p_ptr;
    reg_we_o |-> reg_addr_o == reg_waddr_o + 8'h01;
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer not advanced");
  property p_re;
    reg_re_o |-> busy_o ##1 !reg_re_o;
  endproperty
  a_re: assert property (p_re)
    else $error("bad read strobe");
  property p_mask;
    alert_mask_set_o |-> alert_i ##1 !alert_mask_set_o;
  endproperty
  a_mask: assert property (p_mask)
    else $error("bad mask pulse");
  property p_low;
    low_r == 16'(LOW_TIMEOUT_CYC + 12) |-> !busy_o;
  endproperty
  a_low: assert property (p_low)
    else $error("low timeout missed");
  property p_idle;
    hi_r == 16'h07E4 |-> !busy_o;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle timeout missed");
  c_we: cover property (reg_we_o);
  c_re: cover property (reg_re_o);
  c_mask: cover property (alert_mask_set_o);
endmodule
`default_nettype wire

/* test_smbus_client_interface.sv */
// self-checking bench for the serial client interface
`timescale 1ns/1ns
`default_nettype none
module test_smbus_client_interface;
  import smc_pkg::*;
  localparam logic [6:0] ME = 7'h18;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic alert = 1'b0;
  logic to_en = 1'b0;
  logic [3:0] strap = 4'h0;
  wire logic scl;
  wire logic sda;
  logic sda_out;
  logic oe;
  logic we;
  logic re;
  logic mset;
  logic busy;
  smc_byte_t rdata;
  smc_byte_t raddr;
  smc_byte_t waddr;
  smc_byte_t wdata;
  smc_byte_t mem [256];
  logic [8:0] rx;
  int n_errors = 0;
  int checks_done = 0;
  int masks = 0;
  int reads = 0;
  // strap code in [10:7] beside the own address it selects in [6:0]
  logic [10:0] rows [16] = '{11'h04C, 11'h0CD, 11'h14E, 11'h1CF,
    11'h248, 11'h2C9, 11'h34A, 11'h3CB, 11'h428, 11'h4A9, 11'h52A,
    11'h5AB, 11'h62C, 11'h6AD, 11'h72E, 11'h798};
  always #50 clk = ~clk;
  smc_client #(.LOW_TIMEOUT_CYC(200)) dut (
    .clk_sys_i(clk), .reset_i(rst), .serial_clock_line_i(scl),
    .sda_i(sda), .sda_o(sda_out), .sda_oe_o(oe), .addr_sel_i(strap),
    .alert_i(alert), .timeout_en_i(to_en), .reg_rdata_i(rdata),
    .reg_addr_o(raddr), .reg_waddr_o(waddr), .reg_wdata_o(wdata),
    .reg_we_o(we), .reg_re_o(re), .alert_mask_set_o(mset),
    .busy_o(busy));
  smc_host_model host (.scl_o(scl), .sda_o(sda), .dev_oe_i(oe));
  assign rdata = mem[raddr];
  always @(posedge clk) begin
    if (we)
      mem[waddr] <= wdata;
    if (mset)
      masks <= masks + 1;
    if (re)
      reads <= reads + 1;
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic ack);
    host.xbyte({b, 1'b1}, rx);
    check(9'(rx[0]), 9'(ack));
  endtask
  task automatic get(input logic nack, input logic [7:0] exp);
    host.xbyte({8'hFF, nack}, rx);
    check(9'(rx[8:1]), 9'(exp));
  endtask
  task automatic tick();
    @(posedge clk);
    #2;
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [3:0] code);
    tick();
    strap = code;
    rst = 1'b1;
    repeat (8) tick();
    rst = 1'b0;
    repeat (6) tick();
    check(9'(busy), 9'h000);
    check(9'({oe, sda_out}), 9'h000);
    check(9'(raddr), 9'h000);
  endtask
  initial begin
    #9000000;
    n_errors++;
    test_done();
  end
  initial begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'hA5;
    for (int r = 0; r < 16; r++) begin
      do_reset(rows[r][10:7]);
      host.start_cond();
      send({rows[r][6:0] ^ 7'h01, 1'b0}, 1'b1);
      host.stop_cond();
      host.start_cond();
      send({rows[r][6:0], 1'b0}, 1'b0);
      send(8'(r * 16 + 3), 1'b0);
      host.stop_cond();
      check(9'(raddr), 9'(r * 16 + 3));
    end
    tick();
    to_en = 1'b1;
    // block write wrapping the pointer, one byte under a slow host clock
    host.start_cond();
    send({ME, 1'b0}, 1'b0);
    send(8'hFE, 1'b0);
    host.stretch = 10000;
    send(8'h11, 1'b0);
    host.stretch = 0;
    send(8'h22, 1'b0);
    send(8'h33, 1'b0);
    host.stop_cond();
    check(9'(busy), 9'h000);
    host.start_cond();
    send({ME, 1'b0}, 1'b0);
    send(8'hFE, 1'b0);
    host.start_cond();
    send({ME, 1'b1}, 1'b0);
    get(1'b0, 8'h11);
    get(1'b0, 8'h22);
    get(1'b1, 8'h33);
    host.stop_cond();
    // device stays active here
    host.start_cond();
    send({ME, 1'b1}, 1'b0);
    get(1'b1, 8'hA4);
    host.stop_cond();
    check(9'(reads), 9'h004);
    host.start_cond();
    send({7'h0C, 1'b1}, 1'b1);
    host.stop_cond();
    tick();
    alert = 1'b1;
    host.start_cond();
    send({7'h0C, 1'b1}, 1'b0);
    get(1'b1, {ME, 1'b1});
    host.stop_cond();
    check(9'(masks), 9'h001);
    // host pulls the last address bit low: contest lost, no mask
    host.start_cond();
    send({7'h0C, 1'b1}, 1'b0);
    host.xbyte({8'h30, 1'b1}, rx);
    host.stop_cond();
    check(9'(masks), 9'h001);
    tick();
    alert = 1'b0;
    host.start_cond();
    send({ME, 1'b0}, 1'b0);
    #30000;
    check(9'(busy), 9'h000);
    host.stop_cond();
    tick();
    to_en = 1'b0;
    host.start_cond();
    send({ME, 1'b0}, 1'b0);
    #30000;
    check(9'(busy), 9'h001);
    host.stop_cond();
    tick();
    to_en = 1'b1;
    host.start_cond();
    send({ME, 1'b0}, 1'b0);
    host.park_high(205000);
    check(9'(busy), 9'h000);
    host.stop_cond();
    test_done();
  end
endmodule
bind smc_client smc_client_sva #(.LOW_TIMEOUT_CYC(LOW_TIMEOUT_CYC)) u_sva (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .serial_clock_line_i(serial_clock_line_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alert_i(alert_i),
  .timeout_en_i(timeout_en_i), .reg_addr_o(reg_addr_o),
  .reg_waddr_o(reg_waddr_o), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o),
  .alert_mask_set_o(alert_mask_set_o), .busy_o(busy_o));
`default_nettype wire
